// File: verilog/tmr_mgr_regs.svh
// register offsets, reset values and build defaults of the redundancy manager options
`ifndef TMR_MGR_REGS_SVH
`define TMR_MGR_REGS_SVH
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK_LO     8'h08
`define OFS_MASK_HI     8'h0C
`define OFS_CMP_LO      8'h10
`define OFS_CMP_HI      8'h14
`define OFS_INJ_LO      8'h18
`define OFS_INJ_HI      8'h1C
`define OFS_IRQ_STAT    8'h20
`define OFS_IRQ_MASK    8'h24
`define OFS_SCRUB       8'h28
`define CTRL_MAGIC_LSB  0
`define CTRL_MAGIC_MSB  7
`define STAT_ERR_BIT    0
`define STAT_BRK_BIT    1
`define STAT_BUSY_BIT   2
`define STAT_EXP_BIT    3
`define DEF_MASK_RESET  64'hFFFF_FFFF_FFFF_FFFF
`define DEF_MAGIC1      8'h00
`define DEF_BASE_ADDR   64'h0000_0000_0000_1000
`define DEF_HIGH_ADDR   64'h0000_0000_0000_10FF
`define DEF_ADDR_MASK   64'h0000_0000_FFFF_FF00
`define DEF_HB_WIDTH    16
`define DEF_BRK_WIDTH   0
`define DEF_BRK_RESET   32'h0000_0000
`define IRQ_MASK_RESET  3'h0
`endif

// File: verilog/tmr_mgr_pkg.sv
// types shared by the redundancy manager option logic
package tmr_mgr_pkg;
  typedef enum logic [1:0] {
    TEST_NONE   = 2'b00,
    TEST_READ   = 2'b01,
    TEST_INJECT = 2'b10
  } test_mode_t;

  typedef enum logic [1:0] {
    BRK_IDLE   = 2'b00,
    BRK_COUNT  = 2'b01,
    BRK_BROKEN = 2'b10
  } brk_state_t;

  typedef struct packed {
    logic       heartbeat;
    logic [3:0] status;
  } scrub_in_t;

  typedef struct packed {
    logic expired;
    logic brk;
    logic err;
  } irq_t;
endpackage : tmr_mgr_pkg

// File: verilog/break_delay.sv
// delay from first error to the lockstep break output
`timescale 1ns/1ns
`include "tmr_mgr_regs.svh"
module break_delay #(
  parameter int          WIDTH    = `DEF_BRK_WIDTH,
  parameter logic [31:0] INIT_VAL = `DEF_BRK_RESET
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_clk_en,
  input  wire logic i_error,
  input  wire logic i_restart,
  output logic      o_break,
  output logic      o_busy
);
  tmr_mgr_pkg::brk_state_t state_r;
  logic                    term;

  generate
    if (WIDTH == 0) begin : g_nocnt
      assign term = 1'b1;
    end else begin : g_cnt
      logic [WIDTH-1:0] cnt_r;
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_r <= INIT_VAL[WIDTH-1:0];
        end else if (i_clk_en) begin
          if (i_restart) begin
            cnt_r <= INIT_VAL[WIDTH-1:0];
          end else if (state_r == tmr_mgr_pkg::BRK_COUNT && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      end
      assign term = (cnt_r == '0);
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= tmr_mgr_pkg::BRK_IDLE;
    end else if (i_clk_en) begin
      if (i_restart) begin
        state_r <= tmr_mgr_pkg::BRK_IDLE;
      end else begin
        case (state_r)
          tmr_mgr_pkg::BRK_IDLE: begin
            if (i_error) begin
              state_r <= tmr_mgr_pkg::BRK_COUNT;
            end
          end
          tmr_mgr_pkg::BRK_COUNT: begin
            if (term) begin
              state_r <= tmr_mgr_pkg::BRK_BROKEN;
            end
          end
          tmr_mgr_pkg::BRK_BROKEN: state_r <= tmr_mgr_pkg::BRK_BROKEN;
          default: state_r <= tmr_mgr_pkg::BRK_IDLE;
        endcase
      end
    end
  end

  assign o_break = (state_r == tmr_mgr_pkg::BRK_BROKEN);
  assign o_busy  = (state_r == tmr_mgr_pkg::BRK_COUNT);

  brk_only_term_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_break) |-> $past(state_r) == tmr_mgr_pkg::BRK_COUNT && $past(term))
    else $error("break raised without terminal count");
  brk_needs_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_r == tmr_mgr_pkg::BRK_IDLE && !i_error) ##1 i_clk_en |-> !o_break)
    else $error("break raised without an error");
endmodule : break_delay

// File: verilog/tmr_manager_options.sv
// redundancy manager options: comparator mask, test access, scrubber link, break delay
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "tmr_mgr_regs.svh"
// Notes on behaviour
// - At reset the two mask registers take the halves of a 64-bit mask reset value.
// - Each mask bit enables or silences one comparator.
// - With test access built in, comparator results read back; inject mode adds fault drive.
// - An asynchronous scrubber link passes every scrubber input through two flip-flops.
// - A lapsed heartbeat watchdog raises the expired output and the scrubber status.
// - After an error the break output waits for the break delay to run out.
// - A break delay width of zero builds no delay counter.
// - The break delay counter takes its initial value at reset.
// - An access is ours only when the masked address bits equal the base address.
// - The register window runs from the base address up to the high address.
// - The bus address width may be set from 32 to 64 bits.
// - The bus data path is exactly 32 bits.
// - A control write acts on recovery only if its low byte equals the first magic byte.
module tmr_manager_options #(
  parameter int          ADDR_WIDTH  = 32,
  parameter logic [63:0] BASE_ADDR   = `DEF_BASE_ADDR,
  parameter logic [63:0] HIGH_ADDR   = `DEF_HIGH_ADDR,
  parameter logic [63:0] ADDR_MASK   = `DEF_ADDR_MASK,
  parameter logic [63:0] MASK_RESET  = `DEF_MASK_RESET,
  parameter logic [7:0]  MAGIC1      = `DEF_MAGIC1,
  parameter tmr_mgr_pkg::test_mode_t TEST_MODE = tmr_mgr_pkg::TEST_NONE,
  parameter bit          SCRUB_ASYNC = 1'b1,
  parameter bit          HB_ENABLE   = 1'b1,
  parameter int          HB_WIDTH    = `DEF_HB_WIDTH,
  parameter int          BRK_WIDTH   = `DEF_BRK_WIDTH,
  parameter logic [31:0] BRK_RESET   = `DEF_BRK_RESET
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_clk_en,
  input  wire logic [ADDR_WIDTH-1:0]  i_av_address,
  input  wire logic                   i_av_read,
  input  wire logic                   i_av_write,
  input  wire logic [3:0]             i_av_byteenable,
  input  wire logic [31:0]            i_av_writedata,
  output logic      [31:0]            o_av_readdata,
  output logic                        o_av_waitrequest,
  input  wire logic [63:0]            i_cmp_miscompare,
  output logic      [63:0]            o_cmp_enable,
  output logic      [63:0]            o_cmp_inject,
  input  wire tmr_mgr_pkg::scrub_in_t i_scrub,
  output logic                        o_scrub_pulse_expired,
  output logic                        o_lockstep_break,
  output logic                        o_recover,
  output logic                        o_irq
);
  if (ADDR_WIDTH < 32 || ADDR_WIDTH > 64) begin : g_bad_width
    $error("address width must be 32 to 64");
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a);
    logic [63:0] ax;
    ax = 64'(a);
    return (((ax ^ BASE_ADDR) & ADDR_MASK) == 64'h0) && (ax >= BASE_ADDR) && (ax <= HIGH_ADDR);
  endfunction : addr_hit

  // bus: one wait cycle per access, read data lands at the edge ending the wait, write data at the release edge
  logic        av_req;
  logic        ack_r;
  logic        hit;
  logic [7:0]  ofs;
  logic        wr_go;
  logic [31:0] rd_nxt;
  logic [63:0] ofs_full;

  assign av_req           = i_av_read | i_av_write;
  // a frozen enable keeps the wait, or the master would drop a write that never landed
  assign o_av_waitrequest = av_req & ~(ack_r & i_clk_en);
  assign hit              = addr_hit(i_av_address);
  assign ofs_full         = 64'(i_av_address) - BASE_ADDR;
  assign ofs              = {ofs_full[7:2], 2'b00};
  assign wr_go            = i_av_write & ack_r & hit;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else if (i_clk_en) begin
      ack_r <= av_req & ~ack_r;
    end
  end

  // registers
  logic [31:0]       mask_lo_r;
  logic [31:0]       mask_hi_r;
  logic [31:0]       inj_lo_r;
  logic [31:0]       inj_hi_r;
  logic [63:0]       cmp_last_r;
  tmr_mgr_pkg::irq_t irq_stat_r;
  tmr_mgr_pkg::irq_t irq_mask_r;
  tmr_mgr_pkg::irq_t irq_evt;
  logic              recover_r;
  logic [31:0]       rdata_r;
  logic              err_evt;
  logic              brk_busy;
  logic              expired_r;
  tmr_mgr_pkg::scrub_in_t scrub;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_lo_r <= MASK_RESET[31:0];
      mask_hi_r <= MASK_RESET[63:32];
    end else if (i_clk_en && wr_go) begin
      if (ofs == `OFS_MASK_LO) begin
        mask_lo_r <= be_merge(mask_lo_r, i_av_writedata, i_av_byteenable);
      end
      if (ofs == `OFS_MASK_HI) begin
        mask_hi_r <= be_merge(mask_hi_r, i_av_writedata, i_av_byteenable);
      end
    end
  end

  assign o_cmp_enable = {mask_hi_r, mask_lo_r};
  assign err_evt = |(i_cmp_miscompare & o_cmp_enable);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_last_r <= 64'h0;
      inj_lo_r   <= 32'h0000_0000;
      inj_hi_r   <= 32'h0000_0000;
    end else if (i_clk_en) begin
      // raw results, so a silenced comparator can still be checked alone
      if (TEST_MODE != tmr_mgr_pkg::TEST_NONE) begin
        cmp_last_r <= i_cmp_miscompare;
      end
      if (TEST_MODE == tmr_mgr_pkg::TEST_INJECT && wr_go) begin
        if (ofs == `OFS_INJ_LO) begin
          inj_lo_r <= be_merge(inj_lo_r, i_av_writedata, i_av_byteenable);
        end
        if (ofs == `OFS_INJ_HI) begin
          inj_hi_r <= be_merge(inj_hi_r, i_av_writedata, i_av_byteenable);
        end
      end
    end
  end

  assign o_cmp_inject = {inj_hi_r, inj_lo_r};

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      recover_r <= 1'b0;
    end else if (i_clk_en) begin
      recover_r <= wr_go && (ofs == `OFS_CTRL) && i_av_byteenable[0] &&
                   (i_av_writedata[`CTRL_MAGIC_MSB:`CTRL_MAGIC_LSB] == MAGIC1);
    end
  end

  assign o_recover = recover_r;

  generate
    if (SCRUB_ASYNC) begin : g_sync
      tmr_mgr_pkg::scrub_in_t sync1_r;
      tmr_mgr_pkg::scrub_in_t sync2_r;
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_r <= '0;
          sync2_r <= '0;
        end else if (i_clk_en) begin
          sync1_r <= i_scrub;
          sync2_r <= sync1_r;
        end
      end
      assign scrub = sync2_r;
    end else begin : g_nosync
      assign scrub = i_scrub;
    end
  endgenerate

  generate
    if (HB_ENABLE) begin : g_hb
      logic                hb_prev_r;
      logic [HB_WIDTH-1:0] hb_cnt_r;
      logic                hb_edge;
      assign hb_edge = scrub.heartbeat & ~hb_prev_r;
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          hb_prev_r <= 1'b0;
          hb_cnt_r  <= '1;
          expired_r <= 1'b0;
        end else if (i_clk_en) begin
          hb_prev_r <= scrub.heartbeat;
          if (hb_edge) begin
            hb_cnt_r  <= '1;
            expired_r <= 1'b0;
          end else if (hb_cnt_r != '0) begin
            hb_cnt_r <= hb_cnt_r - 1'b1;
          end else begin
            expired_r <= 1'b1;
          end
        end
      end
      hb_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && hb_edge) |=> hb_cnt_r == '1 && !expired_r)
        else $error("heartbeat edge did not reload the watchdog");
      expired_cause_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(expired_r) |-> $past(i_clk_en) && $past(hb_cnt_r) == '0 && !$past(hb_edge))
        else $error("expired raised before the watchdog ran out");
    end else begin : g_nohb
      assign expired_r = 1'b0;
    end
  endgenerate

  assign o_scrub_pulse_expired = expired_r;

  break_delay #(
    .WIDTH    (BRK_WIDTH),
    .INIT_VAL (BRK_RESET)
  ) u_break (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_error   (err_evt),
    .i_restart (recover_r),
    .o_break   (o_lockstep_break),
    .o_busy    (brk_busy)
  );

  // sticky events, a set in the clearing cycle survives
  assign irq_evt = '{expired: expired_r, brk: o_lockstep_break, err: err_evt};

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= '0;
      irq_mask_r <= `IRQ_MASK_RESET;
    end else if (i_clk_en) begin
      if (wr_go && ofs == `OFS_IRQ_STAT && i_av_byteenable[0]) begin
        irq_stat_r <= (irq_stat_r & ~i_av_writedata[2:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (wr_go && ofs == `OFS_IRQ_MASK && i_av_byteenable[0]) begin
        irq_mask_r <= i_av_writedata[2:0];
      end
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit) begin
      case (ofs)
        `OFS_STATUS: begin
          rd_nxt[`STAT_ERR_BIT]  = err_evt;
          rd_nxt[`STAT_BRK_BIT]  = o_lockstep_break;
          rd_nxt[`STAT_BUSY_BIT] = brk_busy;
          rd_nxt[`STAT_EXP_BIT]  = expired_r;
        end
        `OFS_MASK_LO:  rd_nxt = mask_lo_r;
        `OFS_MASK_HI:  rd_nxt = mask_hi_r;
        `OFS_CMP_LO:   rd_nxt = cmp_last_r[31:0];
        `OFS_CMP_HI:   rd_nxt = cmp_last_r[63:32];
        `OFS_INJ_LO:   rd_nxt = inj_lo_r;
        `OFS_INJ_HI:   rd_nxt = inj_hi_r;
        `OFS_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
        `OFS_IRQ_MASK: rd_nxt = {29'h0, irq_mask_r};
        `OFS_SCRUB:    rd_nxt = {27'h0, expired_r, scrub.status};
        default:       rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_clk_en && i_av_read && !ack_r) begin
      rdata_r <= rd_nxt;
    end
  end

  assign o_av_readdata = rdata_r;

  bus_release_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (av_req && o_av_waitrequest && i_clk_en) ##1 i_clk_en |-> (!o_av_waitrequest || !av_req))
    else $error("waitrequest held more than one cycle");
  mask_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && wr_go && ofs == `OFS_MASK_LO && i_av_byteenable == 4'hF)
    |=> o_cmp_enable[31:0] == $past(i_av_writedata))
    else $error("mask write not applied");
  masked_error_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ((i_cmp_miscompare & o_cmp_enable) == 64'h0) |-> !err_evt)
    else $error("silenced comparator raised an error");
  magic_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_recover && $past(i_clk_en)) |-> $past(i_av_writedata[7:0]) == MAGIC1 && $past(wr_go))
    else $error("recovery without magic byte");
  unmapped_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_av_read && !ack_r && !hit) |=> o_av_readdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  inject_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (TEST_MODE != tmr_mgr_pkg::TEST_INJECT) |-> o_cmp_inject == 64'h0)
    else $error("injection active without inject mode");
  // a mask write landing in the same cycle may legally silence the break bit
  irq_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && o_lockstep_break && irq_mask_r.brk && !(wr_go && ofs == `OFS_IRQ_MASK))
    |=> o_irq)
    else $error("break did not reach interrupt");
  zero_delay_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (BRK_WIDTH == 0 && i_clk_en && err_evt && !recover_r && !o_lockstep_break
     && !brk_busy) ##1 (i_clk_en && !recover_r) |=> o_lockstep_break)
    else $error("zero width delay did not break in two cycles");
  recover_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && o_recover && $past(i_clk_en)) |=> !o_recover)
    else $error("recovery pulse longer than one cycle");
  readdata_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!(i_clk_en && i_av_read && !ack_r)) |=> $stable(o_av_readdata))
    else $error("read data changed outside a read capture");
  inject_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && TEST_MODE == tmr_mgr_pkg::TEST_INJECT && wr_go && ofs == `OFS_INJ_HI
     && i_av_byteenable == 4'hF) |=> o_cmp_inject[63:32] == $past(i_av_writedata))
    else $error("inject write not applied");
  cmp_status_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (TEST_MODE != tmr_mgr_pkg::TEST_NONE && i_clk_en) |=> cmp_last_r == $past(i_cmp_miscompare))
    else $error("comparator status not captured");
  scrub_sync_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (SCRUB_ASYNC && i_clk_en) ##1 i_clk_en |=> scrub == $past(i_scrub, 2))
    else $error("scrubber input not passed through two stages");
  err_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && err_evt) |=> irq_stat_r.err)
    else $error("error event lost against a clear");
  window_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_clk_en && i_av_write && ack_r && !hit) |=> $stable(o_cmp_enable))
    else $error("write outside the window changed the mask");
endmodule : tmr_manager_options

// File: dv/lmb_master.sv
// bus master model that drives the manager register port
`timescale 1ns/1ns
module lmb_master (
  input  wire logic        i_sys_clk,
  input  wire logic        i_av_waitrequest,
  input  wire logic [31:0] i_av_readdata,
  output logic      [31:0] o_av_address,
  output logic             o_av_read,
  output logic             o_av_write,
  output logic      [3:0]  o_av_byteenable,
  output logic      [31:0] o_av_writedata
);
  initial begin
    o_av_address    = 32'h0;
    o_av_read       = 1'b0;
    o_av_write      = 1'b0;
    o_av_byteenable = 4'h0;
    o_av_writedata  = 32'h0;
  end
  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [31:0] adr, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd, output bit ok);
    bit got;
    got = 1'b0;
    rd  = 32'h0;
    @(posedge i_sys_clk);
    o_av_address    <= adr;
    o_av_writedata  <= wd;
    o_av_byteenable <= be;
    o_av_read       <= ~wr;
    o_av_write      <= wr;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge i_sys_clk);
      // values as they stood up to this edge, before the design updates
      got = (i_av_waitrequest === 1'b0);
      if (got) begin
        rd = i_av_readdata;
      end
    end
    ok = got;
    o_av_read       <= 1'b0;
    o_av_write      <= 1'b0;
    // released address and data lines show the inverse, never a stale copy; byteenable keeps its value
    o_av_address    <= ~adr;
    o_av_writedata  <= ~wd;
  endtask : xfer
endmodule : lmb_master

// File: dv/test_tmr_manager_options.sv
// self-checking bench for the redundancy manager options
`timescale 1ns/1ns
`include "tmr_mgr_regs.svh"
module test_tmr_manager_options;
  localparam int          HBW  = 4;
  localparam int          BRKR = 5;
  localparam logic [63:0] MRST = 64'hA5C3_0F0F_1234_FFFF;
  localparam logic [7:0]  MAG  = 8'h5A;
  localparam logic [31:0] BAS  = 32'h0000_1000;
  logic                   sys_clk = 1'b0;
  logic                   rst_n   = 1'b0;
  logic                   clk_en  = 1'b1;
  logic [31:0]            adr;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  logic                   rd;
  logic                   wr;
  logic [3:0]             be;
  logic                   wait_req;
  logic [63:0]            miscmp  = 64'h0;
  logic [63:0]            cmp_en;
  logic [63:0]            cmp_inj;
  tmr_mgr_pkg::scrub_in_t scrub   = '0;
  logic                   expd;
  logic                   brk;
  logic                   rcv;
  logic                   irq;
  logic                   err0    = 1'b0;
  logic                   brk0;
  int                     n_fail  = 0;
  int                     checked = 0;
  int                     n_rcv   = 0;
  int                     cnt;
  logic [31:0]            rng     = 32'h35A3;
  logic [31:0]            expq[$];
  logic [31:0]            got;
  logic [31:0]            v;
  bit                     ok;

  always #2 sys_clk = ~sys_clk;

  tmr_manager_options #(.MASK_RESET(MRST), .MAGIC1(MAG), .TEST_MODE(tmr_mgr_pkg::TEST_INJECT),
    .HB_WIDTH(HBW), .BRK_WIDTH(4), .BRK_RESET(BRKR)) tmr_manager_options_inst (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_av_address(adr),
    .i_av_read(rd), .i_av_write(wr), .i_av_byteenable(be), .i_av_writedata(wdata),
    .o_av_readdata(rdata), .o_av_waitrequest(wait_req), .i_cmp_miscompare(miscmp),
    .o_cmp_enable(cmp_en), .o_cmp_inject(cmp_inj), .i_scrub(scrub),
    .o_scrub_pulse_expired(expd), .o_lockstep_break(brk), .o_recover(rcv), .o_irq(irq));

  // zero width: no delay counter at all, same bus as the first copy
  tmr_manager_options #(.MAGIC1(MAG), .BRK_WIDTH(0), .BRK_RESET(32'h0))
    tmr_manager_options_nodly_inst (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_av_address(adr),
    .i_av_read(rd), .i_av_write(wr), .i_av_byteenable(be), .i_av_writedata(wdata),
    .o_av_readdata(), .o_av_waitrequest(), .i_cmp_miscompare({63'h0, err0}),
    .o_cmp_enable(), .o_cmp_inject(), .i_scrub(scrub), .o_scrub_pulse_expired(),
    .o_lockstep_break(brk0), .o_recover(), .o_irq());

  lmb_master lmb_master_inst (.i_sys_clk(sys_clk), .i_av_waitrequest(wait_req),
    .i_av_readdata(rdata), .o_av_address(adr), .o_av_read(rd), .o_av_write(wr),
    .o_av_byteenable(be), .o_av_writedata(wdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({63'h0, seen}, {63'h0, exp});
  endtask : chk1

  task automatic complete_run;
    // a read whose answer never arrived is a mismatch
    if (expq.size() != 0) n_fail++;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic bus(input logic w, input logic [11:0] ofs, input logic [31:0] d,
                     input logic [3:0] b);
    lmb_master_inst.xfer(w, BAS + {20'h0, ofs}, d, b, got, ok);
    if (!ok) begin
      n_fail++;
      complete_run();
    end
  endtask : bus

  task automatic rd_exp(input logic [11:0] ofs, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, ofs, 32'h0, 4'h0);
  endtask : rd_exp

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wait_cyc

  // read data is judged where the master takes it
  always @(negedge sys_clk) begin
    if (rd === 1'b1 && wait_req === 1'b0 && expq.size() > 0) begin
      check({32'h0, rdata}, {32'h0, expq.pop_front()});
    end
  end

  always @(posedge sys_clk) begin
    if (rcv === 1'b1) n_rcv <= n_rcv + 1;
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    scrub.status <= 4'hA;
    rd_exp(`OFS_MASK_LO, MRST[31:0]);
    rd_exp(`OFS_MASK_HI, MRST[63:32]);
    rd_exp(`OFS_IRQ_MASK, 32'h0);
    check(cmp_en, MRST);
    rng = xs(rng);
    bus(1'b1, `OFS_MASK_LO, rng, 4'h5);
    v = (MRST[31:0] & 32'hFF00_FF00) | (rng & 32'h00FF_00FF);
    rd_exp(`OFS_MASK_LO, v);
    check(cmp_en, {MRST[63:32], v});
    bus(1'b1, `OFS_MASK_LO, 32'h0, 4'hF);
    bus(1'b1, `OFS_MASK_HI, 32'h0, 4'hF);
    rng = xs(rng);
    miscmp <= {rng, ~rng};
    wait_cyc(BRKR + 4);
    chk1(brk, 1'b0);
    rd_exp(`OFS_CMP_LO, ~rng);
    rd_exp(`OFS_CMP_HI, rng);
    rng = xs(rng);
    bus(1'b1, `OFS_INJ_HI, rng, 4'hF);
    rd_exp(`OFS_INJ_HI, rng);
    check(cmp_inj, {rng, 32'h0});
    // one enabled comparator starts the delay
    miscmp <= 64'h1;
    bus(1'b1, `OFS_MASK_LO, 32'h1, 4'hF);
    cnt = 0;
    @(negedge sys_clk);
    while (brk !== 1'b1 && cnt < 40) begin
      @(negedge sys_clk);
      cnt++;
    end
    chk1(cnt >= BRKR + 1 && cnt <= BRKR + 3, 1'b1);
    if (cnt >= 40) begin
      n_fail++;
      complete_run();
    end
    bus(1'b1, `OFS_IRQ_MASK, 32'h2, 4'hF);
    wait_cyc(1);
    chk1(irq, 1'b1);
    bus(1'b1, `OFS_IRQ_STAT, 32'h2, 4'hF);
    wait_cyc(1);
    chk1(irq, 1'b1);
    @(posedge sys_clk);
    miscmp <= 64'h0;
    bus(1'b1, `OFS_CTRL, {24'h0, ~MAG}, 4'hF);
    wait_cyc(3);
    check(n_rcv, 0);
    chk1(brk, 1'b1);
    bus(1'b1, `OFS_CTRL, {24'h0, MAG}, 4'hF);
    wait_cyc(3);
    check(n_rcv, 1);
    chk1(brk, 1'b0);
    bus(1'b1, `OFS_IRQ_STAT, 32'h7, 4'hF);
    wait_cyc(1);
    chk1(irq, 1'b0);
    // heartbeat never toggled so far
    chk1(expd, 1'b1);
    rd_exp(`OFS_SCRUB, 32'h1A);
    scrub.heartbeat <= 1'b1;
    wait_cyc(1);
    chk1(expd, 1'b1);
    for (int i = 0; i < 10; i++) begin
      repeat (4) @(posedge sys_clk);
      scrub.heartbeat <= ~scrub.heartbeat;
    end
    wait_cyc(1);
    chk1(expd, 1'b0);
    // frozen enable: the watchdog must not run out
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wait_cyc((1 << HBW) + 6);
    chk1(expd, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd_exp(`OFS_SCRUB, 32'h0A);
    wait_cyc((1 << HBW) + 6);
    chk1(expd, 1'b1);
    bus(1'b1, `OFS_IRQ_MASK, 32'h4, 4'hF);
    wait_cyc(1);
    chk1(irq, 1'b1);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0, 4'hF);
    wait_cyc(1);
    chk1(irq, 1'b0);
    // outside the window: above high and off the decode mask; 0x02C is an unmapped offset inside it
    bus(1'b1, 12'h10C, 32'hFFFF_FFFF, 4'hF);
    rd_exp(12'h10C, 32'h0);
    rd_exp(`OFS_MASK_HI, 32'h0);
    rd_exp(12'h02C, 32'h0);
    err0 <= 1'b1;
    cnt = 0;
    @(negedge sys_clk);
    while (brk0 !== 1'b1 && cnt < 40) begin
      @(negedge sys_clk);
      cnt++;
    end
    check(cnt, 2);
    if (cnt >= 40) begin
      n_fail++;
      complete_run();
    end
    @(posedge sys_clk);
    err0 <= 1'b0;
    // recovery over the bus returns the zero width delay to idle
    bus(1'b1, `OFS_CTRL, {24'h0, MAG}, 4'hF);
    wait_cyc(2);
    chk1(brk0, 1'b0);
    complete_run();
  end
endmodule : test_tmr_manager_options
